// file: verilog/display_read_sense.sv
// read-class and sense-class command sequencer for the display unit
// assumes buffer storage answers a read strobe with data in the next cycle,
// channel tags arrive asynchronously, everything else is on clk
// Operation
// - reject buffer/position read while regeneration runs
// - buffer address wraps to first location
// - cursor flag stripped from bytes sent
// - read byte, step address, write back
// - parity error flags check, read continues
// - next step stops timing, raises request
// - service out arms spacing delay, then read
// - command out ends counted read
// - cursor search runs until flag found
// - flag found sends cursor-found code
// - no flag: send byte, repeat, next address
// - keyboard read: three bytes, first names source
// - alnum second byte: key or zeros
// - function second byte: five-bit key code
// - third byte: zeros or overlay code
// - repeat latch drives requests, clear ends
// - position read: delay, four bytes, end
// - position returns deflection register coordinates
// - initial load reads from address zero
// - sense: four bytes, address if buffered
// - sense: byte per service out, then end
`timescale 1ns/1ps
`default_nettype none
module display_read_sense (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire drs_pkg::cmd_type cmd_code,
  input wire logic regen_active,
  input wire drs_pkg::buf_word_type buf_rd_word,
  output logic [drs_pkg::BUF_AW-1:0] buf_addr,
  output logic buf_rd,
  output logic buf_wr,
  output drs_pkg::buf_word_type buf_wr_word,
  input wire logic kbd_func,
  input wire logic [7:0] alnum_key,
  input wire logic [4:0] func_key,
  input wire logic [7:0] overlay_code,
  input wire logic [15:0] x_pos,
  input wire logic [15:0] y_pos,
  input wire logic service_out,
  input wire logic command_out,
  output logic service_request,
  output logic [7:0] inbound_bus,
  output drs_pkg::status_type init_status,
  output drs_pkg::status_type end_status,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata
);
  typedef struct packed {
    drs_pkg::state_type st;
    drs_pkg::cmd_type cmd;
    logic [4:0] cnt;
    logic [1:0] lc;
    logic [drs_pkg::BUF_AW-1:0] bac;
    logic [drs_pkg::BUF_AW-1:0] bar;
    drs_pkg::buf_word_type word;
    logic rep;
    logic found;
    logic [1:0] so_sync;
    logic [1:0] co_sync;
    logic req;
    logic [7:0] bus;
    logic brd;
    logic bwr;
    drs_pkg::status_type init_st;
    drs_pkg::status_type end_st;
    logic unit_chk;
    logic reject;
    logic data_check;
    logic regen_bit;
    logic [1:0] ctrl;
    logic [15:0] rdata;
  } seq_type;

  seq_type s;
  seq_type next_s;

  always_comb begin
    logic [7:0] pick;
    logic [7:0] sense0;
    logic [15:0] sense_addr;
    logic counted;
    logic last;
    pick = drs_pkg::BYTE_ZERO;
    sense0 = drs_pkg::BYTE_ZERO;
    sense0[drs_pkg::SNS_CMD_REJECT] = s.reject;
    sense0[drs_pkg::SNS_DATA_CHECK] = s.data_check;
    sense0[drs_pkg::SNS_REGEN_ACTIVE] = s.regen_bit;
    sense_addr = s.ctrl[drs_pkg::CTRL_HAS_BUF] ? 16'(s.bac) : 16'h0000;
    counted = (s.cmd == drs_pkg::CMD_RKBD) || (s.cmd == drs_pkg::CMD_RPOS)
      || (s.cmd == drs_pkg::CMD_SENSE);
    last = (s.cmd == drs_pkg::CMD_RKBD) ? (s.lc == drs_pkg::LC_KBD_LAST)
      : (s.lc == drs_pkg::LC_FOUR_LAST);
    // byte for the counted transfers
    unique case (s.cmd)
      drs_pkg::CMD_RKBD: begin
        unique case (s.lc)
          2'h0: pick = kbd_func ? drs_pkg::KBD_ID_FUNC : drs_pkg::KBD_ID_ALNUM;
          2'h1: begin
            if (kbd_func) begin
              pick = {3'h0, func_key};
            end else if (s.ctrl[drs_pkg::CTRL_HAS_BUF] && s.ctrl[drs_pkg::CTRL_HAS_CG]) begin
              pick = drs_pkg::BYTE_ZERO;
            end else begin
              pick = alnum_key;
            end
          end
          default: pick = kbd_func ? overlay_code : drs_pkg::BYTE_ZERO;
        endcase
      end
      drs_pkg::CMD_RPOS: begin
        unique case (s.lc)
          2'h0: pick = x_pos[15:8];
          2'h1: pick = x_pos[7:0];
          2'h2: pick = y_pos[15:8];
          default: pick = y_pos[7:0];
        endcase
      end
      drs_pkg::CMD_SENSE: begin
        unique case (s.lc)
          2'h0: pick = sense0;
          2'h1: pick = drs_pkg::BYTE_ZERO;
          2'h2: pick = sense_addr[15:8];
          default: pick = sense_addr[7:0];
        endcase
      end
      default: pick = drs_pkg::BYTE_ZERO;
    endcase

    next_s = s;
    next_s.so_sync = {s.so_sync[0], service_out};
    next_s.co_sync = {s.co_sync[0], command_out};
    next_s.brd = 1'b0;
    next_s.bwr = 1'b0;
    next_s.init_st = '0;
    next_s.end_st = '0;
    next_s.rdata = 16'h0000;
    if (s.cnt != drs_pkg::CNT_ZERO) begin
      next_s.cnt = s.cnt - drs_pkg::CNT_STEP;
    end

    unique case (s.st)
      drs_pkg::ST_IDLE: begin
        if (cmd_valid && cmd_code <= drs_pkg::CMD_SENSE) begin
          next_s.cmd = cmd_code;
          next_s.lc = drs_pkg::LC_ZERO;
          next_s.rep = 1'b0;
          next_s.found = 1'b0;
          next_s.init_st.valid = 1'b1;
          if ((cmd_code == drs_pkg::CMD_RBUF || cmd_code == drs_pkg::CMD_RPOS)
              && regen_active) begin
            next_s.init_st.unit_check = 1'b1;
            next_s.reject = 1'b1;
            next_s.regen_bit = 1'b1;
          end else if (cmd_code == drs_pkg::CMD_RKBD || cmd_code == drs_pkg::CMD_SENSE) begin
            next_s.rep = 1'b1;
            next_s.st = drs_pkg::ST_SVC;
          end else if (cmd_code == drs_pkg::CMD_RPOS) begin
            next_s.cnt = drs_pkg::POS_DELAY_CYC;
            next_s.rep = 1'b1;
            next_s.st = drs_pkg::ST_PREP;
          end else begin
            if (cmd_code == drs_pkg::CMD_RIPL) begin
              next_s.bac = drs_pkg::BUF_FIRST;
            end
            next_s.cnt = drs_pkg::WAIT_ONE_CYC;
            next_s.st = drs_pkg::ST_PREP;
          end
        end
      end
      drs_pkg::ST_PREP: begin
        if (s.cnt == drs_pkg::CNT_ZERO) begin
          if (s.cmd == drs_pkg::CMD_RPOS) begin
            next_s.st = drs_pkg::ST_SVC;
          end else begin
            next_s.bar = s.bac;
            next_s.brd = 1'b1;
            next_s.st = drs_pkg::ST_RD;
          end
        end
      end
      drs_pkg::ST_RD: next_s.st = drs_pkg::ST_STP;
      drs_pkg::ST_STP: begin
        next_s.word = buf_rd_word;
        next_s.bwr = 1'b1;
        next_s.st = drs_pkg::ST_WB;
        next_s.bac = (s.bac == drs_pkg::BUF_LAST) ? drs_pkg::BUF_FIRST
          : s.bac + drs_pkg::BUF_STEP;
      end
      drs_pkg::ST_WB: begin
        if (!(^{s.word.data, s.word.parity})) begin
          next_s.data_check = 1'b1;
          next_s.unit_chk = 1'b1;
        end
        next_s.st = drs_pkg::ST_NXT;
      end
      drs_pkg::ST_NXT: begin
        next_s.req = 1'b1;
        next_s.st = drs_pkg::ST_SVC;
        if (s.cmd == drs_pkg::CMD_RCUR && s.word.cursor) begin
          next_s.bus = drs_pkg::CURSOR_FOUND;
          next_s.found = 1'b1;
          next_s.rep = 1'b0;
        end else begin
          next_s.bus = s.word.data;
          next_s.rep = (s.cmd == drs_pkg::CMD_RCUR);
        end
      end
      drs_pkg::ST_SVC: begin
        if (s.req && s.co_sync[1]) begin
          next_s.req = 1'b0;
          next_s.st = drs_pkg::ST_ENDG;
        end else if (s.req && s.so_sync[1]) begin
          next_s.req = 1'b0;
          if (counted) begin
            next_s.lc = last ? drs_pkg::LC_ZERO : s.lc + drs_pkg::LC_STEP;
            next_s.rep = !last;
            if (last) begin
              next_s.st = drs_pkg::ST_ENDG;
            end
          end else if (s.found) begin
            next_s.st = drs_pkg::ST_ENDG;
          end else begin
            next_s.cnt = drs_pkg::WAIT_ONE_CYC;
            next_s.st = drs_pkg::ST_PREP;
          end
        end else if (!s.req && counted && s.rep && !s.so_sync[1] && !s.co_sync[1]) begin
          next_s.req = 1'b1;
          next_s.bus = pick;
        end
      end
      drs_pkg::ST_ENDG: begin
        next_s.end_st.valid = 1'b1;
        next_s.end_st.unit_check = s.unit_chk;
        next_s.unit_chk = 1'b0;
        next_s.found = 1'b0;
        next_s.rep = 1'b0;
        next_s.lc = drs_pkg::LC_ZERO;
        if (s.cmd == drs_pkg::CMD_SENSE) begin
          next_s.reject = 1'b0;
          next_s.data_check = 1'b0;
          next_s.regen_bit = 1'b0;
        end
        next_s.st = drs_pkg::ST_IDLE;
      end
    endcase

    // register port
    if (reg_wr && reg_addr == drs_pkg::REG_CTRL) begin
      next_s.ctrl = reg_wdata[1:0];
    end
    if (reg_wr && reg_addr == drs_pkg::REG_BADDR && s.st == drs_pkg::ST_IDLE) begin
      next_s.bac = reg_wdata[drs_pkg::BUF_AW-1:0];
    end
    if (reg_rd) begin
      unique case (reg_addr)
        drs_pkg::REG_CTRL: next_s.rdata = {14'h0000, s.ctrl};
        drs_pkg::REG_BADDR: next_s.rdata = 16'(s.bac);
        drs_pkg::REG_SENSE: next_s.rdata = {sense0, drs_pkg::BYTE_ZERO};
        drs_pkg::REG_STAT: next_s.rdata = {10'h000, s.req, s.rep, 1'b0, 3'(s.st)};
        default: next_s.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{st: drs_pkg::ST_IDLE, cmd: drs_pkg::CMD_RBUF, ctrl: drs_pkg::CTRL_RESET,
        default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign buf_addr = s.bar;
  assign buf_rd = s.brd;
  assign buf_wr = s.bwr;
  assign buf_wr_word = s.word;
  assign service_request = s.req;
  assign inbound_bus = s.bus;
  assign init_status = s.init_st;
  assign end_status = s.end_st;
  assign reg_rdata = s.rdata;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence read_issue;
    s.st == drs_pkg::ST_RD && buf_rd;
  endsequence

  sequence buf_accept;
    s.st == drs_pkg::ST_SVC && s.req && s.so_sync[1] && !s.co_sync[1]
      && s.cmd == drs_pkg::CMD_RBUF;
  endsequence

  chk_reject_status: assert property (
    s.st == drs_pkg::ST_IDLE && cmd_valid && regen_active
    && (cmd_code == drs_pkg::CMD_RBUF || cmd_code == drs_pkg::CMD_RPOS)
    |=> init_status.unit_check && s.reject && s.regen_bit && s.st == drs_pkg::ST_IDLE)
    else $error("reject status missing");
  chk_addr_wrap: assert property (
    s.st == drs_pkg::ST_STP && s.bac == drs_pkg::BUF_LAST |=> s.bac == drs_pkg::BUF_FIRST)
    else $error("buffer address did not wrap");
  chk_data_only: assert property (
    s.st == drs_pkg::ST_NXT && s.cmd == drs_pkg::CMD_RBUF |=> inbound_bus == $past(s.word.data))
    else $error("bus byte differs from buffer data");
  chk_write_back: assert property (
    read_issue |-> ##2 (buf_wr && buf_addr == $past(buf_addr, 2)))
    else $error("write back missing or misaddressed");
  chk_parity_flag: assert property (
    s.st == drs_pkg::ST_WB && !(^{s.word.data, s.word.parity}) |=> s.data_check && s.unit_chk)
    else $error("parity error not flagged");
  chk_service_raise: assert property (
    s.st == drs_pkg::ST_NXT |=> service_request && s.st == drs_pkg::ST_SVC)
    else $error("no service request after next step");
  chk_prep_arm: assert property (
    buf_accept |=> s.st == drs_pkg::ST_PREP && s.cnt == drs_pkg::WAIT_ONE_CYC)
    else $error("spacing delay not armed");
  chk_prep_expire: assert property (
    s.st == drs_pkg::ST_PREP && s.cnt == drs_pkg::CNT_ZERO && s.cmd == drs_pkg::CMD_RBUF
    |=> buf_rd && s.st == drs_pkg::ST_RD)
    else $error("read pulse not issued after delay");
  chk_stop_ending: assert property (
    s.st == drs_pkg::ST_SVC && s.req && s.co_sync[1] |=> s.st == drs_pkg::ST_ENDG ##1 end_status.valid)
    else $error("command out did not end the read");
  chk_cursor_found: assert property (
    s.st == drs_pkg::ST_NXT && s.cmd == drs_pkg::CMD_RCUR && s.word.cursor
    |=> inbound_bus == drs_pkg::CURSOR_FOUND && service_request)
    else $error("cursor found code not presented");
  chk_found_ending: assert property (
    s.st == drs_pkg::ST_SVC && s.req && s.so_sync[1] && !s.co_sync[1] && s.found
    |=> s.st == drs_pkg::ST_ENDG)
    else $error("cursor search did not end after found code");
  chk_repeat_request: assert property (
    s.st == drs_pkg::ST_SVC && !s.req && s.rep && s.cmd == drs_pkg::CMD_RKBD
    && !s.so_sync[1] && !s.co_sync[1] |=> service_request)
    else $error("no new request while repeat latch set");
  chk_pos_delay: assert property (
    s.st == drs_pkg::ST_IDLE && cmd_valid && cmd_code == drs_pkg::CMD_RPOS && !regen_active
    |=> s.st == drs_pkg::ST_PREP && s.cnt == drs_pkg::POS_DELAY_CYC
      && s.lc == drs_pkg::LC_ZERO)
    else $error("position read delay not armed");
  chk_sense_ending: assert property (
    s.st == drs_pkg::ST_SVC && s.req && s.so_sync[1] && !s.co_sync[1]
    && s.cmd == drs_pkg::CMD_SENSE && s.lc == drs_pkg::LC_FOUR_LAST
    |=> s.st == drs_pkg::ST_ENDG && s.lc == drs_pkg::LC_ZERO)
    else $error("sense did not end after fourth byte");
endmodule
`default_nettype wire

// file: shared/drs_pkg.sv
// constants and carrier types for the read and sense command sequencer
// assumes one 25 MHz clock shared by the sequencer, buffer storage and command decoder
package drs_pkg;
  localparam int CLK_NS = 40;
  localparam int WAIT_ONE_NS = 1000;
  localparam int POS_DELAY_NS = 250;
  localparam logic [4:0] WAIT_ONE_CYC = 5'((WAIT_ONE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] POS_DELAY_CYC = 5'((POS_DELAY_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [4:0] CNT_STEP = 5'h01;

  localparam int BUF_AW = 13;
  localparam logic [BUF_AW-1:0] BUF_FIRST = 13'h0000;
  localparam logic [BUF_AW-1:0] BUF_LAST = 13'h1FFF;
  localparam logic [BUF_AW-1:0] BUF_STEP = 13'h0001;

  // byte sent when a cursor flag is met; arbitrary value
  localparam logic [7:0] CURSOR_FOUND = 8'hFF;
  localparam logic [7:0] KBD_ID_ALNUM = 8'h80;
  localparam logic [7:0] KBD_ID_FUNC = 8'h40;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  localparam logic [1:0] LC_ZERO = 2'h0;
  localparam logic [1:0] LC_STEP = 2'h1;
  localparam logic [1:0] LC_KBD_LAST = 2'h2;
  localparam logic [1:0] LC_FOUR_LAST = 2'h3;

  localparam int SNS_CMD_REJECT = 7;
  localparam int SNS_DATA_CHECK = 4;
  localparam int SNS_REGEN_ACTIVE = 2;

  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_BADDR = 4'h4;
  localparam logic [3:0] REG_SENSE = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hC;
  localparam int CTRL_HAS_BUF = 0;
  localparam int CTRL_HAS_CG = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;

  typedef enum logic [2:0] {
    CMD_RBUF = 3'h0, CMD_RCUR = 3'h1, CMD_RKBD = 3'h2,
    CMD_RPOS = 3'h3, CMD_RIPL = 3'h4, CMD_SENSE = 3'h5
  } cmd_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_PREP = 3'h1, ST_RD = 3'h3, ST_STP = 3'h2,
    ST_WB = 3'h6, ST_NXT = 3'h7, ST_SVC = 3'h5, ST_ENDG = 3'h4
  } state_type;

  typedef struct packed {
    logic cursor;
    logic parity;
    logic [7:0] data;
  } buf_word_type;

  typedef struct packed {
    logic valid;
    logic unit_check;
  } status_type;
endpackage

// file: tb/channel_model.sv
// host channel model: answers service requests with service out or command out
// assumes tags are sampled by the sequencer through its own synchronizers
`timescale 1ns/1ps
`default_nettype none
module channel_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clear,
  input wire logic slow,
  input wire logic [7:0] limit,
  input wire logic service_request,
  input wire logic [7:0] inbound_bus,
  output logic service_out,
  output logic command_out
);
  logic [7:0] got [0:15];
  logic [7:0] n;
  logic [3:0] dly;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      service_out <= 1'b0;
      command_out <= 1'b0;
      n <= 8'h00;
      dly <= 4'h0;
    end else if (clear) begin
      n <= 8'h00;
    end else if (service_out || command_out) begin
      if (!service_request) begin
        service_out <= 1'b0;
        command_out <= 1'b0;
        dly <= 4'h0;
      end
    end else if (service_request) begin
      if (slow && dly != 4'h5) begin
        dly <= dly + 4'h1;
      // byte count spent: stop with command out
      end else if (n == limit) begin
        command_out <= 1'b1;
      end else begin
        service_out <= 1'b1;
        got[n[3:0]] <= inbound_bus;
        n <= n + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/test_display_read_sense.sv
// self-checking bench for the read and sense command sequencer
// assumes the channel model and a behavioural buffer store in this module
`timescale 1ns/1ps
`default_nettype none
module test_display_read_sense;
  logic clk, rst_b, cmd_valid, regen_active, kbd_func, reg_wr, reg_rd, slow;
  drs_pkg::cmd_type cmd_code;
  drs_pkg::buf_word_type buf_rd_word, buf_wr_word;
  logic [12:0] buf_addr, cur_addr, bad_addr;
  logic buf_rd, buf_wr, service_out, command_out, service_request;
  logic [7:0] alnum_key, overlay_code, inbound_bus, limit;
  logic [4:0] func_key;
  logic [15:0] x_pos, y_pos, reg_wdata, reg_rdata;
  logic [3:0] reg_addr;
  drs_pkg::status_type init_status, end_status;
  logic end_seen, init_uc, end_uc;
  int error_cnt, total_checks;

  display_read_sense DUT (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .regen_active(regen_active), .buf_rd_word(buf_rd_word),
    .buf_addr(buf_addr), .buf_rd(buf_rd), .buf_wr(buf_wr), .buf_wr_word(buf_wr_word),
    .kbd_func(kbd_func), .alnum_key(alnum_key), .func_key(func_key),
    .overlay_code(overlay_code), .x_pos(x_pos), .y_pos(y_pos),
    .service_out(service_out), .command_out(command_out),
    .service_request(service_request), .inbound_bus(inbound_bus),
    .init_status(init_status), .end_status(end_status), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  channel_model chan (.clk(clk), .rst_b(rst_b), .clear(cmd_valid), .slow(slow),
    .limit(limit), .service_request(service_request), .inbound_bus(inbound_bus),
    .service_out(service_out), .command_out(command_out));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // buffer contents: odd parity except at bad_addr, cursor at cur_addr
  function automatic drs_pkg::buf_word_type word_at(input logic [12:0] a);
    word_at.data = a[7:0] ^ 8'h5A;
    word_at.cursor = (a == cur_addr);
    word_at.parity = (~^word_at.data) ^ (a == bad_addr);
  endfunction

  always @(posedge clk) begin
    buf_rd_word <= buf_rd ? word_at(buf_addr) : ~buf_rd_word;
    if (buf_wr) check_val(16'(buf_wr_word), 16'(word_at(buf_addr)));
    if (cmd_valid) end_seen <= 1'b0;
    if (init_status.valid) init_uc <= init_status.unit_check;
    if (end_status.valid) begin
      end_seen <= 1'b1;
      end_uc <= end_status.unit_check;
    end
  end

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_check(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check_val(reg_rdata, exp);
  endtask

  task automatic run(input drs_pkg::cmd_type c, input logic [7:0] lim,
                     input logic [7:0] nexp);
    int k;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    limit <= lim;
    @(posedge clk);
    cmd_valid <= 1'b0;
    repeat (2) @(posedge clk);
    k = 0;
    while (end_seen !== 1'b1 && init_uc !== 1'b1 && k < 2000) begin
      @(posedge clk);
      k++;
    end
    check_val(16'(k < 2000), 16'h0001);
    check_val(16'(chan.n), 16'(nexp));
  endtask

  task automatic log_check(input int cnt, input logic [31:0] exp);
    for (int i = 0; i < cnt; i++) check_val(16'(chan.got[i]), 16'(exp[31-8*i -: 8]));
  endtask

  task automatic results;
    if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    results();
  end

  initial begin
    logic [7:0] kb [0:2][0:3];
    kb = '{'{8'h00, 8'h80, 8'h3C, 8'h00}, '{8'h01, 8'h40, 8'h15, 8'hC3},
           '{8'h03, 8'h80, 8'h00, 8'h00}};
    rst_b = 1'b0; cmd_valid = 1'b0; cmd_code = drs_pkg::CMD_RBUF; regen_active = 1'b0;
    kbd_func = 1'b0; alnum_key = 8'h3C; func_key = 5'h15; overlay_code = 8'hC3;
    x_pos = 16'h1234; y_pos = 16'hABCD; reg_addr = 4'h0; reg_wdata = 16'h0000;
    reg_wr = 1'b0; reg_rd = 1'b0; slow = 1'b0; limit = 8'hFF; buf_rd_word = '0;
    cur_addr = 13'h1FFF; bad_addr = 13'h0000; end_seen = 1'b0;
    init_uc = 1'b0; end_uc = 1'b0; error_cnt = 0; total_checks = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    reg_check(drs_pkg::REG_CTRL, 16'h0001);
    reg_check(4'h2, 16'h0000);
    reg_write(drs_pkg::REG_BADDR, 16'h0123);
    reg_check(drs_pkg::REG_BADDR, 16'h0123);
    regen_active <= 1'b1;
    run(drs_pkg::CMD_RBUF, 8'hFF, 8'h00);
    check_val(16'(init_uc), 16'h0001);
    run(drs_pkg::CMD_RPOS, 8'hFF, 8'h00);
    check_val(16'(init_uc), 16'h0001);
    regen_active <= 1'b0;
    run(drs_pkg::CMD_SENSE, 8'hFF, 8'h04);
    log_check(4, 32'h84000123);
    reg_write(drs_pkg::REG_BADDR, 16'h1FFE);
    run(drs_pkg::CMD_RBUF, 8'h03, 8'h03);
    log_check(3, {word_at(13'h1FFE).data, word_at(13'h1FFF).data,
                  word_at(13'h0000).data, 8'h00});
    check_val(16'(end_uc), 16'h0001);
    run(drs_pkg::CMD_SENSE, 8'hFF, 8'h04);
    check_val(16'(chan.got[0]), 16'h0010);
    cur_addr = 13'h0012;
    reg_write(drs_pkg::REG_BADDR, 16'h0010);
    run(drs_pkg::CMD_RCUR, 8'hFF, 8'h03);
    log_check(3, {word_at(13'h0010).data, word_at(13'h0011).data,
                  drs_pkg::CURSOR_FOUND, 8'h00});
    for (int i = 0; i < 3; i++) begin
      reg_write(drs_pkg::REG_CTRL, 16'(kb[i][0][1:0]));
      kbd_func <= kb[i][0][0] & ~kb[i][0][1];
      run(drs_pkg::CMD_RKBD, 8'hFF, 8'h03);
      log_check(3, {kb[i][1], kb[i][2], kb[i][3], 8'h00});
    end
    slow <= 1'b1;
    run(drs_pkg::CMD_RPOS, 8'hFF, 8'h04);
    log_check(4, {x_pos, y_pos});
    slow <= 1'b0;
    reg_write(drs_pkg::REG_BADDR, 16'h0050);
    run(drs_pkg::CMD_RIPL, 8'h02, 8'h02);
    log_check(2, {word_at(13'h0000).data, word_at(13'h0001).data, 16'h0000});
    reg_write(drs_pkg::REG_CTRL, 16'h0000);
    run(drs_pkg::CMD_SENSE, 8'hFF, 8'h04);
    check_val({chan.got[2], chan.got[3]}, 16'h0000);
    results();
  end
endmodule
`default_nettype wire
